// ===== verification/emcr_error_monitor_regs_tb.sv
// self-checking bench for the error monitor register slice
`timescale 1ns/1ns
module emcr_error_monitor_regs_tb;
   logic clk = 0, rst = 1, we = 0, re = 0, run = 0, en = 0;
   logic flt = 0, mrst = 0;
   logic [7:0] adr = 8'h00, wd = 8'h00;
   logic [3:0] lim = 4'h0;
   wire [7:0] rdat, hx, hn, lx, ln;
   wire [4:0] cnt;
   wire hit, rv, refd, hnd, dclr, lkd, sreq, sack;
   int n_mismatch = 0;
   int n_compared = 0;
   emcr_error_monitor_regs u_dut (.I_CLK(clk), .I_SYS_RST(rst),
      .I_REG_ADDR(adr), .I_REG_WDATA(wd), .I_REG_WE(we), .I_REG_RE(re),
      .O_REG_HIT(hit), .O_REG_RDATA(rdat), .O_REG_RVALID(rv),
      .O_WRITE_REFUSED(refd), .I_MONITOR_RUN(run), .I_MONITOR_ENABLE(en),
      .I_FAULT_COUNT_LIMIT(lim), .I_MONITOR_FAULT(flt), .I_MCU_RESET(mrst),
      .O_HIGH_PULSE_MAX(hx), .O_HIGH_PULSE_MIN(hn), .O_LOW_PULSE_MAX(lx),
      .O_LOW_PULSE_MIN(ln), .O_FAULT_COUNT(cnt), .O_FAULT_HANDLING(hnd),
      .O_DRIVER_ENABLE_CLR(dclr), .O_REGS_LOCKED(lkd),
      .O_SHUTDOWN_REQ(sreq), .I_SHUTDOWN_ACK(sack));
   emcr_seq_model #(.ACK_DLY(3)) u_seq (.i_clk(clk), .i_rst(rst),
      .i_req(sreq), .o_ack(sack));
   initial
   begin
      forever #2 clk = ~clk;
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // strobes last one cycle; results are looked at one ns after the edge, hit one ns after re rises
   // an idle edge leads each strobe, so calls in a row never retoggle it
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      adr = a;
      wd = d;
      we = 1;
      @(posedge clk);
      #1 we = 0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1;
      adr = a;
      re = 1;
      #1 chk("hit", 8'h01, {7'h00, hit});
      @(posedge clk);
      #1 re = 0;
      chk("rvalid", 8'h01, {7'h00, rv});
      chk("rdata", e, rdat);
   endtask
   task pulse(input int n);
      flt = 1;
      repeat (n) @(posedge clk);
      #1 flt = 0;
   endtask
   task t_reset;
      static logic [7:0] a[7] = '{8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
         8'hA1, 8'hA7};
      foreach (a[i]) rd(a[i], 8'h00);
      $display("t_reset done");
   endtask
   task t_thresh;
      for (int i = 0; i < 4; i++) wr(8'h93 + i, 8'h11 * (i + 1));
      chk("hmax", 8'h11, hx);
      chk("hmin", 8'h22, hn);
      chk("lmax", 8'h33, lx);
      chk("lmin", 8'h44, ln);
      for (int i = 0; i < 4; i++) rd(8'h93 + i, 8'h11 * (i + 1));
      run = 1;
      wr(8'h93, 8'hFF);
      chk("refused", 8'h01, {7'h00, refd});
      rd(8'h93, 8'h11);
      run = 0;
      $display("t_thresh done");
   endtask
   task t_lock;
      wr(8'hA1, 8'h9A);
      chk("locked", 8'h01, {7'h00, lkd});
      rd(8'hA1, 8'h01);
      wr(8'h94, 8'h77);
      chk("refused", 8'h01, {7'h00, refd});
      rd(8'h94, 8'h22);
      wr(8'hA1, 8'h9B);
      rd(8'hA1, 8'h00);
      wr(8'h94, 8'h77);
      rd(8'h94, 8'h77);
      wr(8'h97, 8'hFF);
      chk("refused", 8'h01, {7'h00, refd});
      rd(8'h97, 8'h00);
      @(posedge clk);
      #1;
      adr = 8'hA0;
      re = 1;
      #1 chk("unmapped hit", 8'h00, {7'h00, hit});
      @(posedge clk);
      #1 re = 0;
      chk("unmapped", 8'h00, {7'h00, rv});
      $display("t_lock done");
   endtask
   task t_count;
      lim = 4'h2;
      en = 1;
      run = 1;
      pulse(3);
      rd(8'h97, 8'h03);
      chk("handling", 8'h01, {7'h00, hnd});
      chk("drvclr", 8'h00, {7'h00, dclr});
      mrst = 1;
      @(posedge clk);
      #1 mrst = 0;
      chk("count", 8'h00, {3'h0, cnt});
      pulse(40);
      rd(8'h97, 8'h1F);
      run = 0;
      @(posedge clk);
      #1 chk("count", 8'h00, {3'h0, cnt});
      chk("drvclr", 8'h01, {7'h00, dclr});
      en = 0;
      $display("t_count done");
   endtask
   task t_reboot;
      wr(8'hA7, 8'h5A);
      chk("shutreq", 8'h01, {7'h00, sreq});
      // the sequencer model acks on the fourth edge; the request drops next
      repeat (4) @(posedge clk);
      #1 chk("shutreq", 8'h01, {7'h00, sreq});
      @(posedge clk);
      #1 chk("shutreq", 8'h00, {7'h00, sreq});
      rd(8'hA7, 8'h5A);
      wr(8'hA1, 8'h00);
      wr(8'hA7, 8'h33);
      chk("refused", 8'h01, {7'h00, refd});
      chk("shutreq", 8'h00, {7'h00, sreq});
      $display("t_reboot done");
   endtask
   task wrap_up;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #4000;
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst = 0;
      t_reset;
      t_thresh;
      t_lock;
      t_count;
      t_reboot;
      wrap_up;
   end
endmodule // emcr_error_monitor_regs_tb

// ===== verification/emcr_regs_sva.sv
// assertions on the register slice ports
`timescale 1ns/1ns
module emcr_regs_sva
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_REG_WE,
   input wire logic I_REG_RE,
   input wire logic [7:0] O_REG_RDATA,
   input wire logic O_REG_RVALID,
   input wire logic O_WRITE_REFUSED,
   input wire logic I_MONITOR_RUN,
   input wire logic I_MONITOR_ENABLE,
   input wire logic [3:0] I_FAULT_COUNT_LIMIT,
   input wire logic I_MCU_RESET,
   input wire logic [7:0] O_HIGH_PULSE_MAX,
   input wire logic [7:0] O_HIGH_PULSE_MIN,
   input wire logic [7:0] O_LOW_PULSE_MAX,
   input wire logic [7:0] O_LOW_PULSE_MIN,
   input wire logic [4:0] O_FAULT_COUNT,
   input wire logic O_FAULT_HANDLING,
   input wire logic O_DRIVER_ENABLE_CLR,
   input wire logic O_REGS_LOCKED
);
   default clocking dc @(posedge I_CLK);
   endclocking
   default disable iff (I_SYS_RST);
   sequence s_key_wr;
      I_REG_WE && I_REG_ADDR == 8'hA1;
   endsequence
   sequence s_boot_wr;
      I_REG_WE && I_REG_ADDR == 8'hA7;
   endsequence
   property p_unlock;
      s_key_wr ##0 I_REG_WDATA == 8'h9B |=> !O_REGS_LOCKED;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock failed");
   property p_lock;
      s_key_wr ##0 I_REG_WDATA != 8'h9B |=> O_REGS_LOCKED;
   endproperty
   a_lock: assert property (p_lock) else $error("lock failed");
   property p_lock_rd;
      I_REG_RE && I_REG_ADDR == 8'hA1 && !I_REG_WE |=>
         O_REG_RVALID && O_REG_RDATA == {7'h00, O_REGS_LOCKED};
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lock read");
   property p_cnt_rd;
      I_REG_RE && I_REG_ADDR == 8'h97 |=>
         O_REG_RDATA == {3'h0, $past(O_FAULT_COUNT)};
   endproperty
   a_cnt_rd: assert property (p_cnt_rd) else $error("count read");
   property p_cnt_clr;
      !I_MONITOR_RUN || I_MCU_RESET |=> O_FAULT_COUNT == 5'h00;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("count clear");
   property p_thr_hold;
      I_REG_WE && I_MONITOR_RUN |=> $stable(O_HIGH_PULSE_MAX) &&
         $stable(O_HIGH_PULSE_MIN) && $stable(O_LOW_PULSE_MAX) &&
         $stable(O_LOW_PULSE_MIN);
   endproperty
   a_thr_hold: assert property (p_thr_hold) else $error("thr moved");
   property p_thr_wr;
      I_REG_WE && I_REG_ADDR == 8'h93 && !I_MONITOR_RUN && !O_REGS_LOCKED
         |=> O_HIGH_PULSE_MAX == $past(I_REG_WDATA);
   endproperty
   a_thr_wr: assert property (p_thr_wr) else $error("thr write");
   property p_boot_ref;
      s_boot_wr ##0 O_REGS_LOCKED |=> O_WRITE_REFUSED;
   endproperty
   a_boot_ref: assert property (p_boot_ref) else $error("locked wr");
   property p_handle;
      I_MONITOR_RUN && O_FAULT_COUNT > {1'b0, I_FAULT_COUNT_LIMIT}
         |=> O_FAULT_HANDLING;
   endproperty
   a_handle: assert property (p_handle) else $error("no handling");
   property p_drv_clr;
      I_MONITOR_ENABLE && !I_MONITOR_RUN |=> O_DRIVER_ENABLE_CLR;
   endproperty
   a_drv_clr: assert property (p_drv_clr) else $error("no drv clr");
endmodule // emcr_regs_sva
bind emcr_error_monitor_regs emcr_regs_sva u_sva (.*);

// ===== verification/emcr_seq_model.sv
// power sequencer stand-in that acknowledges shutdown requests
`timescale 1ns/1ns
module emcr_seq_model
#(
   parameter ACK_DLY = 3
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   output logic o_ack = 1'b0
);
   int wait_q;
   // acks a held request after a fixed delay, one cycle wide
   always @(posedge i_clk)
   begin
      o_ack <= 1'b0;
      if (i_rst || !i_req)
         wait_q <= 0;
      else if (wait_q == ACK_DLY)
      begin
         o_ack <= 1'b1;
         wait_q <= 0;
      end
      else
         wait_q <= wait_q + 1;
   end
endmodule // emcr_seq_model

// ===== verilog/emcr_error_monitor_regs.v
// error monitor threshold, fault counter, lock and soft reboot registers
`timescale 1ns/1ns
`include "emcr_regs.vh"
module emcr_error_monitor_regs
#(
   parameter DATA_W = 8,
   parameter CNT_W = 5,
   parameter LIMIT_W = 4
)
(
   input wire I_CLK,
   input wire I_SYS_RST,
   // register port from the serial interface
   input wire [7:0] I_REG_ADDR,
   input wire [DATA_W-1:0] I_REG_WDATA,
   input wire I_REG_WE,
   input wire I_REG_RE,
   output wire O_REG_HIT,
   output reg [DATA_W-1:0] O_REG_RDATA,
   output reg O_REG_RVALID,
   output reg O_WRITE_REFUSED,
   // monitor side
   input wire I_MONITOR_RUN,
   input wire I_MONITOR_ENABLE,
   input wire [LIMIT_W-1:0] I_FAULT_COUNT_LIMIT,
   input wire I_MONITOR_FAULT,
   input wire I_MCU_RESET,
   output wire [DATA_W-1:0] O_HIGH_PULSE_MAX,
   output wire [DATA_W-1:0] O_HIGH_PULSE_MIN,
   output wire [DATA_W-1:0] O_LOW_PULSE_MAX,
   output wire [DATA_W-1:0] O_LOW_PULSE_MIN,
   output wire [CNT_W-1:0] O_FAULT_COUNT,
   output reg O_FAULT_HANDLING,
   output reg O_DRIVER_ENABLE_CLR,
   // lock and power sequencing
   output wire O_REGS_LOCKED,
   output reg O_SHUTDOWN_REQ,
   input wire I_SHUTDOWN_ACK
);

   // -------------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------------
   function is_slice_addr;
      input [7:0] addr;
      begin
         is_slice_addr = 1'b0;
         if (addr == `EMCR_OFF_HIGH_PULSE_MAX)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_HIGH_PULSE_MIN)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_LOW_PULSE_MAX)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_LOW_PULSE_MIN)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_FAULT_COUNTER)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_WRITE_PROTECT_KEY)
            is_slice_addr = 1'b1;
         else if (addr == `EMCR_OFF_SOFT_REBOOT)
            is_slice_addr = 1'b1;
      end
   endfunction

   // threshold offsets are contiguous but are decoded one by one
   function is_threshold_addr;
      input [7:0] addr;
      begin
         is_threshold_addr = 1'b0;
         if (addr == `EMCR_OFF_HIGH_PULSE_MAX)
            is_threshold_addr = 1'b1;
         else if (addr == `EMCR_OFF_HIGH_PULSE_MIN)
            is_threshold_addr = 1'b1;
         else if (addr == `EMCR_OFF_LOW_PULSE_MAX)
            is_threshold_addr = 1'b1;
         else if (addr == `EMCR_OFF_LOW_PULSE_MIN)
            is_threshold_addr = 1'b1;
      end
   endfunction

   wire slice_hit;
   wire thresh_hit;
   wire wr_hmax;
   wire wr_hmin;
   wire wr_lmax;
   wire wr_lmin;
   wire thresh_wr_ok;
   wire reboot_wr;
   wire lock_wr;
   wire refused;

   assign slice_hit = is_slice_addr(I_REG_ADDR);
   assign thresh_hit = is_threshold_addr(I_REG_ADDR);
   assign O_REG_HIT = slice_hit;

   // -------------------------------------------------------------------
   // lock state
   // -------------------------------------------------------------------
   reg locked_q;
   reg locked_d;

   // the lock register itself is never gated, else it could not reopen
   assign lock_wr = I_REG_WE &&
      (I_REG_ADDR == `EMCR_OFF_WRITE_PROTECT_KEY);

   always @*
   begin
      locked_d = locked_q;
      if (lock_wr)
      begin
         if (I_REG_WDATA == `EMCR_UNLOCK_KEY)
         begin
            locked_d = `EMCR_UNLOCKED;
         end
         else
         begin
            locked_d = `EMCR_LOCKED;
         end
      end
   end

   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         locked_q <= `EMCR_UNLOCKED;
      end
      else
      begin
         locked_q <= locked_d;
      end
   end

   assign O_REGS_LOCKED = locked_q;

   // -------------------------------------------------------------------
   // threshold registers
   // -------------------------------------------------------------------
   // a running monitor must not see its limits move under it
   assign thresh_wr_ok = I_REG_WE && !I_MONITOR_RUN && !locked_q;
   assign wr_hmax = thresh_wr_ok &&
      (I_REG_ADDR == `EMCR_OFF_HIGH_PULSE_MAX);
   assign wr_hmin = thresh_wr_ok &&
      (I_REG_ADDR == `EMCR_OFF_HIGH_PULSE_MIN);
   assign wr_lmax = thresh_wr_ok &&
      (I_REG_ADDR == `EMCR_OFF_LOW_PULSE_MAX);
   assign wr_lmin = thresh_wr_ok &&
      (I_REG_ADDR == `EMCR_OFF_LOW_PULSE_MIN);

   emcr_thresh_reg
   #(
      .WIDTH(DATA_W),
      .RESET_VALUE(`EMCR_RESET_VALUE)
   )
   u_high_pulse_max
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_wr_en(wr_hmax),
      .i_wdata(I_REG_WDATA),
      .o_value(O_HIGH_PULSE_MAX)
   );

   emcr_thresh_reg
   #(
      .WIDTH(DATA_W),
      .RESET_VALUE(`EMCR_RESET_VALUE)
   )
   u_high_pulse_min
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_wr_en(wr_hmin),
      .i_wdata(I_REG_WDATA),
      .o_value(O_HIGH_PULSE_MIN)
   );

   emcr_thresh_reg
   #(
      .WIDTH(DATA_W),
      .RESET_VALUE(`EMCR_RESET_VALUE)
   )
   u_low_pulse_max
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_wr_en(wr_lmax),
      .i_wdata(I_REG_WDATA),
      .o_value(O_LOW_PULSE_MAX)
   );

   emcr_thresh_reg
   #(
      .WIDTH(DATA_W),
      .RESET_VALUE(`EMCR_RESET_VALUE)
   )
   u_low_pulse_min
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_wr_en(wr_lmin),
      .i_wdata(I_REG_WDATA),
      .o_value(O_LOW_PULSE_MIN)
   );

   // -------------------------------------------------------------------
   // fault counter and escalation
   // -------------------------------------------------------------------
   emcr_fault_counter
   #(
      .WIDTH(CNT_W)
   )
   u_fault_counter
   (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_run(I_MONITOR_RUN),
      .i_mcu_reset(I_MCU_RESET),
      .i_fault(I_MONITOR_FAULT),
      .o_count(O_FAULT_COUNT)
   );

   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_FAULT_HANDLING <= 1'b0;
         O_DRIVER_ENABLE_CLR <= 1'b0;
      end
      else
      begin
         O_FAULT_HANDLING <= I_MONITOR_RUN &&
            (O_FAULT_COUNT > {1'b0, I_FAULT_COUNT_LIMIT});
         O_DRIVER_ENABLE_CLR <= I_MONITOR_ENABLE && !I_MONITOR_RUN;
      end
   end

   // -------------------------------------------------------------------
   // soft reboot trigger
   // -------------------------------------------------------------------
   reg [DATA_W-1:0] reboot_id_q;

   assign reboot_wr = I_REG_WE && !locked_q &&
      (I_REG_ADDR == `EMCR_OFF_SOFT_REBOOT);

   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         reboot_id_q <= `EMCR_RESET_VALUE;
      end
      else if (reboot_wr)
      begin
         reboot_id_q <= I_REG_WDATA;
      end
   end

   // request is held until the sequencer takes it; a new write wins
   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_SHUTDOWN_REQ <= 1'b0;
      end
      else if (reboot_wr)
      begin
         O_SHUTDOWN_REQ <= 1'b1;
      end
      else if (I_SHUTDOWN_ACK)
      begin
         O_SHUTDOWN_REQ <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // refused writes
   // -------------------------------------------------------------------
   assign refused = I_REG_WE && slice_hit && !lock_wr && !reboot_wr &&
      !(thresh_hit && thresh_wr_ok);

   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_WRITE_REFUSED <= 1'b0;
      end
      else
      begin
         O_WRITE_REFUSED <= refused;
      end
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   reg [DATA_W-1:0] rdata_d;

   always @*
   begin
      rdata_d = {DATA_W{1'b0}};
      if (I_REG_ADDR == `EMCR_OFF_HIGH_PULSE_MAX)
         rdata_d = O_HIGH_PULSE_MAX;
      else if (I_REG_ADDR == `EMCR_OFF_HIGH_PULSE_MIN)
         rdata_d = O_HIGH_PULSE_MIN;
      else if (I_REG_ADDR == `EMCR_OFF_LOW_PULSE_MAX)
         rdata_d = O_LOW_PULSE_MAX;
      else if (I_REG_ADDR == `EMCR_OFF_LOW_PULSE_MIN)
         rdata_d = O_LOW_PULSE_MIN;
      else if (I_REG_ADDR == `EMCR_OFF_FAULT_COUNTER)
         rdata_d[`EMCR_FAULT_CNT_MSB:0] = O_FAULT_COUNT;
      else if (I_REG_ADDR == `EMCR_OFF_WRITE_PROTECT_KEY)
         rdata_d[`EMCR_LOCK_STATUS_BIT] = locked_q;
      else if (I_REG_ADDR == `EMCR_OFF_SOFT_REBOOT)
         rdata_d = reboot_id_q;
   end

   always @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         O_REG_RDATA <= `EMCR_RESET_VALUE;
         O_REG_RVALID <= 1'b0;
      end
      else
      begin
         O_REG_RVALID <= I_REG_RE && slice_hit;
         if (I_REG_RE && slice_hit)
         begin
            O_REG_RDATA <= rdata_d;
         end
      end
   end

endmodule // emcr_error_monitor_regs

// ===== verilog/emcr_fault_counter.v
// saturating monitor fault counter with clear on stop or mcu reset
`timescale 1ns/1ns
`include "emcr_regs.vh"
module emcr_fault_counter
#(
   parameter WIDTH = 5
)
(
   input wire i_clk,
   input wire i_rst,
   input wire i_run,
   input wire i_mcu_reset,
   input wire i_fault,
   output wire [WIDTH-1:0] o_count
);

   localparam [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
   localparam [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

   reg [WIDTH-1:0] count_q;
   reg [WIDTH-1:0] count_d;

   // saturate rather than wrap so a long fault burst never looks healthy
   always @*
   begin
      count_d = count_q;
      if (!i_run || i_mcu_reset)
      begin
         count_d = {WIDTH{1'b0}};
      end
      else if (i_fault && count_q != CNT_MAX)
      begin
         count_d = count_q + CNT_ONE;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         count_q <= {WIDTH{1'b0}};
      end
      else
      begin
         count_q <= count_d;
      end
   end

   assign o_count = count_q;

endmodule // emcr_fault_counter

// ===== verilog/emcr_regs.vh
// register offsets, field positions, reset values and keys of the slice
`ifndef EMCR_REGS_VH
`define EMCR_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EMCR_ADDR_W 8
`define EMCR_DATA_W 8
`define EMCR_OFF_HIGH_PULSE_MAX 8'h93
`define EMCR_OFF_HIGH_PULSE_MIN 8'h94
`define EMCR_OFF_LOW_PULSE_MAX 8'h95
`define EMCR_OFF_LOW_PULSE_MIN 8'h96
`define EMCR_OFF_FAULT_COUNTER 8'h97
`define EMCR_OFF_WRITE_PROTECT_KEY 8'hA1
`define EMCR_OFF_SOFT_REBOOT 8'hA7

// ----------------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------------
`define EMCR_RESET_VALUE 8'h00
`define EMCR_UNLOCK_KEY 8'h9B
`define EMCR_FAULT_CNT_W 5
`define EMCR_FAULT_CNT_MSB 4
`define EMCR_FAULT_LIMIT_W 4
`define EMCR_LOCK_STATUS_BIT 0
`define EMCR_LOCKED 1'b1
`define EMCR_UNLOCKED 1'b0

`endif

// ===== verilog/emcr_thresh_reg.v
// one pulse-duration threshold register with a write gate
`timescale 1ns/1ns
module emcr_thresh_reg
#(
   parameter WIDTH = 8,
   parameter [WIDTH-1:0] RESET_VALUE = 8'h00
)
(
   input wire i_clk,
   input wire i_rst,
   input wire i_wr_en,
   input wire [WIDTH-1:0] i_wdata,
   output wire [WIDTH-1:0] o_value
);

   reg [WIDTH-1:0] value_q;
   reg [WIDTH-1:0] value_d;

   always @*
   begin
      value_d = value_q;
      if (i_wr_en)
      begin
         value_d = i_wdata;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         value_q <= RESET_VALUE;
      end
      else
      begin
         value_q <= value_d;
      end
   end

   assign o_value = value_q;

endmodule // emcr_thresh_reg
